// >>> src/sprx_pkg.sv
// package: register map, field layout and types for the s/pdif receiver status block
//
// Behaviour
// - stream-format bits 9:6 report detected right channel word length code
// - stream-format bits 5:2 report detected left channel word length code
// - 20-bit max codes: 16=0010 17=1100 18=0100 19=1000 20=1010
// - 24-bit max codes: 20=0011 21=1101 22=0101 23=1001 24=1011
// - stream-format bit 0 reads 0 for linear pcm, 1 for compressed
// - stream-format bit 1 gives compression family, meaningful only when compressed
// - read-only 16-bit compression code register, reset zero
// - losing lock mutes the receiver audio output; a loss in the cycle that auto-resume restarts from muted leaves it playing
// - auto-resume 0 (reset value): stay muted after relock
// - auto-resume 1: restart audio on relock and clear sticky lock-lost
// - lock lost after acquisition sets read-only sticky flag, held while auto-resume is 0
// - sticky flag clears only while auto-resume is 1
// - clock-rate select resets 1: 0 full system clock, 1 divided by two
// - read-only lock flag: 1 when locked, 0 with no valid input
package sprx_pkg;
  localparam logic [15:0] ADDR_LOCK     = 16'hF600;
  localparam logic [15:0] ADDR_FORMAT   = 16'hF602;
  localparam logic [15:0] ADDR_COMPCODE = 16'hF603;
  localparam logic [15:0] ADDR_RESUME   = 16'hF604;
  localparam logic [15:0] ADDR_LOSTFLAG = 16'hF605;
  localparam logic [15:0] ADDR_RATESEL  = 16'hF606;
  localparam logic [15:0] ADDR_INTSTAT  = 16'hF610;
  localparam logic [15:0] ADDR_INTMASK  = 16'hF611;
  localparam int          BYTE_SHIFT    = 2;

  localparam int RIGHT_LSB  = 6;
  localparam int LEFT_LSB   = 2;
  localparam int FAMILY_BIT = 1;
  localparam int COMPR_BIT  = 0;

  localparam logic [15:0] RESET_FORMAT   = 16'h0000;
  localparam logic [15:0] RESET_COMPCODE = 16'h0000;
  localparam logic        RESET_RESUME   = 1'b0;
  localparam logic        RESET_RATESEL  = 1'b1;

  localparam logic [3:0] WL_16 = 4'h2;
  localparam logic [3:0] WL_17 = 4'hC;
  localparam logic [3:0] WL_18 = 4'h4;
  localparam logic [3:0] WL_19 = 4'h8;
  localparam logic [3:0] WL_20 = 4'hA;
  localparam logic [3:0] WL_20_OF_24 = 4'h3;
  localparam logic [3:0] WL_21 = 4'hD;
  localparam logic [3:0] WL_22 = 4'h5;
  localparam logic [3:0] WL_23 = 4'h9;
  localparam logic [3:0] WL_24 = 4'hB;

  // interrupt status bits
  localparam int IRQ_LOST   = 0;
  localparam int IRQ_RELOCK = 1;
  localparam int IRQ_FORMAT = 2;
  localparam int IRQ_W      = 3;

  typedef struct packed {
    logic [3:0]  right_word_len_code;
    logic [3:0]  left_word_len_code;
    logic        compression_family_flag;
    logic        compressed;
    logic [15:0] compression_code;
  } sprx_status_t;

  typedef enum logic [2:0] {
    SPRX_UNLOCKED = 3'b001,
    SPRX_PLAYING  = 3'b010,
    SPRX_MUTED    = 3'b100
  } sprx_state_t;
endpackage

// >>> src/sprx_top.sv
// module: s/pdif receiver status decode, mute/relock control and apb register slave
`timescale 1ns/1ps
module sprx_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 rx_lock_in,
  input  wire sprx_pkg::sprx_status_t rx_status_in,
  output logic                      audio_mute,
  output logic                      rx_clock_rate_select,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: lock and decoded channel status come from the link side
  logic                   lock_s1;
  logic                   lock_s2;
  logic                   lock_q;
  sprx_pkg::sprx_status_t stat_s1;
  sprx_pkg::sprx_status_t stat_s2;
  sprx_pkg::sprx_status_t stat_q;
  logic                   stat_steady;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      lock_q  <= 1'b0;
    end else begin
      lock_s1 <= rx_lock_in;
      lock_s2 <= lock_s1;
      lock_q  <= lock_s2;
    end
  end

  // status bits may skew between lanes; they are only sampled while lock is steady
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_s1 <= '0;
      stat_s2 <= '0;
    end else begin
      stat_s1 <= rx_status_in;
      stat_s2 <= stat_s1;
    end
  end

  // a word must repeat on two edges before it is taken, so a half-changed word is never kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_s2;
    end
  end

  assign stat_steady = (stat_s2 == stat_q);

  logic lock_rise;
  logic lock_fall;
  assign lock_rise = lock_s2 & ~lock_q;
  assign lock_fall = ~lock_s2 & lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic        acc;
  logic        wr;
  logic        rd;
  logic [15:0] word_addr;
  logic        hit;
  assign acc       = psel & penable;
  // writes land on the edge at which the master sees pready
  assign wr        = acc & pwrite & pready;
  assign rd        = acc & ~pwrite;
  assign word_addr = paddr[17:2];

  always_comb begin
    hit = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (word_addr == sprx_pkg::ADDR_LOCK) begin
      hit = 1'b1;
    end else if (word_addr == sprx_pkg::ADDR_FORMAT) begin
      hit = 1'b1;
    end else if (word_addr == sprx_pkg::ADDR_COMPCODE) begin
      hit = 1'b1;
    end else if (word_addr == sprx_pkg::ADDR_RESUME) begin
      hit = 1'b1;
    end else if (word_addr == sprx_pkg::ADDR_LOSTFLAG) begin
      hit = 1'b1;
    end else if (word_addr == sprx_pkg::ADDR_RATESEL) begin
      hit = 1'b1;
    end else if (word_addr == sprx_pkg::ADDR_INTSTAT) begin
      hit = 1'b1;
    end else if (word_addr == sprx_pkg::ADDR_INTMASK) begin
      hit = 1'b1;
    end
  end

  // low byte lane carries every writable bit
  logic wr_low;
  assign wr_low = wr & hit & pstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic auto_resume;
  logic resume_q;
  logic [sprx_pkg::IRQ_W-1:0] int_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_resume <= sprx_pkg::RESET_RESUME;
    end else if (wr_low && word_addr == sprx_pkg::ADDR_RESUME) begin
      auto_resume <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_q <= sprx_pkg::RESET_RESUME;
    end else begin
      resume_q <= auto_resume;
    end
  end

  logic resume_rise;
  assign resume_rise = auto_resume & ~resume_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_clock_rate_select <= sprx_pkg::RESET_RATESEL;
    end else if (wr_low && word_addr == sprx_pkg::ADDR_RATESEL) begin
      rx_clock_rate_select <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= '0;
    end else if (wr_low && word_addr == sprx_pkg::ADDR_INTMASK) begin
      int_mask <= pwdata[sprx_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded format capture
  sprx_pkg::sprx_status_t fmt;
  logic                   fmt_change;
  assign fmt_change = lock_q & lock_s2 & stat_steady & (stat_s2 != fmt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt <= '0;
    end else if (lock_q && lock_s2 && stat_steady) begin
      fmt <= stat_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mute / relock state machine
  sprx_pkg::sprx_state_t state;
  sprx_pkg::sprx_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      sprx_pkg::SPRX_UNLOCKED: begin
        if (lock_rise) begin
          next_state = sprx_pkg::SPRX_PLAYING;
        end
      end
      sprx_pkg::SPRX_PLAYING: begin
        if (lock_fall) begin
          next_state = sprx_pkg::SPRX_MUTED;
        end
      end
      sprx_pkg::SPRX_MUTED: begin
        // manual restart: a 0 to 1 write while locked restarts the receiver
        if (lock_q && (auto_resume || resume_rise)) begin
          next_state = sprx_pkg::SPRX_PLAYING;
        end else begin
          next_state = sprx_pkg::SPRX_MUTED;
        end
      end
      default: next_state = sprx_pkg::SPRX_UNLOCKED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sprx_pkg::SPRX_UNLOCKED;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      audio_mute <= 1'b1;
    end else begin
      audio_mute <= (next_state != sprx_pkg::SPRX_PLAYING);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky lock-lost flag; a loss in the clearing cycle wins
  logic sticky_lock_lost;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_lock_lost <= 1'b0;
    end else if (lock_fall && state != sprx_pkg::SPRX_UNLOCKED) begin
      sticky_lock_lost <= 1'b1;
    end else if (auto_resume && lock_q) begin
      sticky_lock_lost <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, cleared by a read, set wins over clear
  logic [sprx_pkg::IRQ_W-1:0] int_stat;
  logic [sprx_pkg::IRQ_W-1:0] int_evt;
  logic                       stat_rd;
  logic [sprx_pkg::IRQ_W-1:0] next_int_stat;
  assign int_evt[sprx_pkg::IRQ_LOST]   = lock_fall;
  assign int_evt[sprx_pkg::IRQ_RELOCK] = lock_rise;
  assign int_evt[sprx_pkg::IRQ_FORMAT] = fmt_change;
  // clear only where prdata is loaded; a second clear would drop an event arriving between
  assign stat_rd = rd & ~pready & (paddr[1:0] == 2'b00) &
                   (word_addr == sprx_pkg::ADDR_INTSTAT);

  always_comb begin
    next_int_stat = int_stat | int_evt;
    if (stat_rd) begin
      next_int_stat = int_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
    end else begin
      int_stat <= next_int_stat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_mask & next_int_stat);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped or misaligned answers slverr with zero data
  logic [15:0] rd_word;

  always_comb begin
    rd_word = 16'h0000;
    if (word_addr == sprx_pkg::ADDR_LOCK) begin
      rd_word = {15'h0000, lock_q};
    end else if (word_addr == sprx_pkg::ADDR_FORMAT) begin
      rd_word = 16'h0000;
      rd_word[sprx_pkg::RIGHT_LSB +: 4] = fmt.right_word_len_code;
      rd_word[sprx_pkg::LEFT_LSB +: 4]  = fmt.left_word_len_code;
      rd_word[sprx_pkg::FAMILY_BIT]     = fmt.compression_family_flag;
      rd_word[sprx_pkg::COMPR_BIT]      = fmt.compressed;
    end else if (word_addr == sprx_pkg::ADDR_COMPCODE) begin
      rd_word = fmt.compression_code;
    end else if (word_addr == sprx_pkg::ADDR_RESUME) begin
      rd_word = {15'h0000, auto_resume};
    end else if (word_addr == sprx_pkg::ADDR_LOSTFLAG) begin
      rd_word = {15'h0000, sticky_lock_lost};
    end else if (word_addr == sprx_pkg::ADDR_RATESEL) begin
      rd_word = {15'h0000, rx_clock_rate_select};
    end else if (word_addr == sprx_pkg::ADDR_INTSTAT) begin
      rd_word = {13'h0000, int_stat};
    end else if (word_addr == sprx_pkg::ADDR_INTMASK) begin
      rd_word = {13'h0000, int_mask};
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= (hit && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
      pslverr <= ~hit;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

endmodule // sprx_top

// >>> verif/sprx_top_asserts.sv
// checker: port-level timing rules of the receiver status block
`timescale 1ns/1ps
module sprx_top_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        rx_lock_in,
  input wire logic        audio_mute,
  input wire logic        rx_clock_rate_select
);
  localparam logic [31:0] A_LOCK = {14'h0, sprx_pkg::ADDR_LOCK, 2'h0};
  localparam logic [31:0] A_RES  = {14'h0, sprx_pkg::ADDR_RESUME, 2'h0};
  localparam logic [31:0] A_RATE = {14'h0, sprx_pkg::ADDR_RATESEL, 2'h0};
  logic wr_ack;
  logic resume_q;
  logic played;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_ack = psel && penable && pready && pwrite && pstrb[0];
  // shadow of the auto-resume bit, since the register itself is not a port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) resume_q <= 1'h0;
    else if (wr_ack && paddr == A_RES) resume_q <= pwdata[0];
  end
  // muted from reset counts as first start, not as a relock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) played <= 1'h0;
    else played <= played | !audio_mute;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_rd_lock;
    psel && penable && pready && !pwrite && paddr == A_LOCK;
  endsequence
  sequence s_wr_rate;
    wr_ack && paddr == A_RATE;
  endsequence
  a_mute_on_loss: assert property ($fell(rx_lock_in) |-> ##[1:6] audio_mute)
    else $error("no mute after lock loss");
  a_mute_unlocked: assert property (!rx_lock_in [*5] |-> audio_mute)
    else $error("playing without lock");
  a_stay_muted: assert property (audio_mute && played && !resume_q &&
    !(wr_ack && paddr == A_RES) |=> audio_mute)
    else $error("audio resumed with auto-resume off");
  a_resume_plays: assert property ((resume_q && rx_lock_in) [*8] |-> !audio_mute)
    else $error("no restart with auto-resume on");
  a_lock_read_hi: assert property (rx_lock_in [*6] ##0 s_rd_lock |-> prdata[0])
    else $error("lock flag low while locked");
  a_lock_read_lo: assert property (!rx_lock_in [*6] ##0 s_rd_lock |-> !prdata[0])
    else $error("lock flag high while unlocked");
  a_rate_reset: assert property ($rose(presetn) |-> rx_clock_rate_select)
    else $error("rate select not 1 after reset");
  a_rate_write: assert property (s_wr_rate |=> rx_clock_rate_select == $past(pwdata[0]))
    else $error("rate select not following write");
endmodule // sprx_top_asserts
bind sprx_top sprx_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .prdata, .rx_lock_in, .audio_mute, .rx_clock_rate_select);

// >>> verif/sprx_src_model.sv
// partner model: s/pdif source feeding lock and decoded channel status
`timescale 1ns/1ps
module sprx_src_model (
  input  wire logic                   pclk,
  input  wire logic                   lock_cmd,
  input  wire sprx_pkg::sprx_status_t status_cmd,
  output logic                        rx_lock_in,
  output sprx_pkg::sprx_status_t      rx_status_in
);
  initial begin
    rx_lock_in = 1'h0;
    rx_status_in = '0;
  end
  always @(posedge pclk) begin
    rx_lock_in <= lock_cmd;
    // unlocked lines churn, so held fields must come from the block itself
    rx_status_in <= lock_cmd ? status_cmd : ~rx_status_in;
  end
endmodule // sprx_src_model

// >>> verif/sprx_top_tb_top.sv
// testbench: apb register tests of the receiver status block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module sprx_top_tb_top;
  logic                   pclk, presetn, psel, penable, pwrite, lock_cmd;
  logic [31:0]            paddr, pwdata, prdata, rdata;
  logic [3:0]             pstrb;
  logic                   pready, pslverr, rerr, rx_lock_in, audio_mute, rate_sel, irq;
  sprx_pkg::sprx_status_t status_cmd, rx_status_in;
  int                     bad_count = 0;
  int                     compares = 0;
  int                     cyc = 0;
  logic [3:0]             wl [10] = '{4'h2, 4'hC, 4'h4, 4'h8, 4'hA, 4'h3, 4'hD, 4'h5, 4'h9, 4'hB};
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  sprx_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .rx_lock_in, .rx_status_in, .audio_mute, .rx_clock_rate_select(rate_sel),
    .irq);
  sprx_src_model u_src (.pclk, .lock_cmd, .status_cmd, .rx_lock_in, .rx_status_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk_rd(input logic [15:0] idx, input logic [31:0] e, input logic ee = 1'h0);
    xfer(1'h0, idx, 32'h0);
    `CHK(rdata, e)
    `CHK(rerr, ee)
  endtask
  task automatic set_lock(input logic v);
    @(posedge pclk);
    lock_cmd <= v;
    repeat (8) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // the whole sequence needs a few hundred cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, lock_cmd, presetn} = '0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    status_cmd = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    `CHK(audio_mute, 1'h1)
    `CHK(rate_sel, 1'h1)
    chk_rd(sprx_pkg::ADDR_COMPCODE, 32'h0);
    chk_rd(sprx_pkg::ADDR_RESUME, 32'h0);
    chk_rd(sprx_pkg::ADDR_LOSTFLAG, 32'h0);
    chk_rd(sprx_pkg::ADDR_RATESEL, 32'h1);
    chk_rd(16'hF607, 32'h0, 1'h1);
    for (int v = 0; v < 2; v++) begin
      xfer(1'h1, sprx_pkg::ADDR_RATESEL, 32'(v));
      @(posedge pclk);
      `CHK(rate_sel, v[0])
      chk_rd(sprx_pkg::ADDR_RATESEL, 32'(v));
    end
    xfer(1'h1, sprx_pkg::ADDR_INTMASK, 32'h7);
    set_lock(1'h1);
    `CHK(audio_mute, 1'h0)
    chk_rd(sprx_pkg::ADDR_LOCK, 32'h1);
    for (int i = 0; i < 10; i++) begin
      status_cmd <= {wl[i], wl[9-i], i[0], i[1], 16'h1000 + 16'(i)};
      repeat (6) @(posedge pclk);
      chk_rd(sprx_pkg::ADDR_FORMAT, {22'h0, wl[i], wl[9-i], i[0], i[1]});
      chk_rd(sprx_pkg::ADDR_COMPCODE, 32'h1000 + 32'(i));
    end
    xfer(1'h1, sprx_pkg::ADDR_FORMAT, 32'hFFFF);
    chk_rd(sprx_pkg::ADDR_FORMAT, {22'h0, wl[9], wl[0], 2'h2});
    `CHK(irq, 1'h1)
    chk_rd(sprx_pkg::ADDR_INTSTAT, 32'h6);
    set_lock(1'h0);
    `CHK(audio_mute, 1'h1)
    chk_rd(sprx_pkg::ADDR_LOCK, 32'h0);
    chk_rd(sprx_pkg::ADDR_COMPCODE, 32'h1009);
    xfer(1'h1, sprx_pkg::ADDR_LOSTFLAG, 32'h0);
    chk_rd(sprx_pkg::ADDR_LOSTFLAG, 32'h1);
    chk_rd(sprx_pkg::ADDR_INTSTAT, 32'h1);
    xfer(1'h1, sprx_pkg::ADDR_INTMASK, 32'h0);
    set_lock(1'h1);
    `CHK(audio_mute, 1'h1)
    `CHK(irq, 1'h0)
    xfer(1'h1, sprx_pkg::ADDR_INTMASK, 32'h7);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'h1)
    chk_rd(sprx_pkg::ADDR_INTSTAT, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'h0)
    chk_rd(sprx_pkg::ADDR_LOSTFLAG, 32'h1);
    xfer(1'h1, sprx_pkg::ADDR_RESUME, 32'h1);
    xfer(1'h1, sprx_pkg::ADDR_RESUME, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(audio_mute, 1'h0)
    chk_rd(sprx_pkg::ADDR_LOSTFLAG, 32'h0);
    xfer(1'h1, sprx_pkg::ADDR_RESUME, 32'h1);
    set_lock(1'h0);
    chk_rd(sprx_pkg::ADDR_LOSTFLAG, 32'h1);
    set_lock(1'h1);
    `CHK(audio_mute, 1'h0)
    chk_rd(sprx_pkg::ADDR_LOSTFLAG, 32'h0);
    end_of_test();
  end
endmodule // sprx_top_tb_top
